// >>> tb.sv
// Self-checking bench for the output clock and frame pulse control block
`timescale 1ns/1ps
module tb
	import tcfoc_pkg::*;
;
	logic        clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 0, en, sel;
	logic [31:0] pwdata = 0, prdata, q;
	logic        pready, pslverr, e, switchSoftReset;
	logic [3:0]  rateClock = 0, oc, ocOe, fp, fpOe, sc, sp;
	logic        refFrame = 0;
	logic [2:0]  dpIn = 0, dp, dpOe, sd;
	int          fail_count = 0, cmp_count = 0, cyc = 0;

	always #50 clock = ~clock;

	tcfoc_ctrl DUT (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rateClock(rateClock),
		.refFrame(refFrame), .delayedPulseIn(dpIn),
		.switchSoftReset(switchSoftReset), .outClock(oc), .outClockOe(ocOe),
		.outFramePulse(fp), .outFramePulseOe(fpOe), .delayedFramePulse(dp),
		.delayedFramePulseOe(dpOe));
	tcfoc_sink SINK (.clk(oc), .clkOe(ocOe), .pul(fp), .pulOe(fpOe), .dly(dp),
		.dlyOe(dpOe), .seenClk(sc), .seenPul(sp), .seenDly(sd));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer, held until pready is sampled high
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1;
		@(posedge clock);
		// Only pready ends the wait; the hang guard covers a dead slave
		while (pready !== 1'b1)
			@(posedge clock);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// Expected clock pins: pair 3 source picked by rate code
	function logic [3:0] expClk(logic [15:0] s, logic [3:0] r);
		for (int i = 0; i < 4; i++)
			expClk[i] = (i < 3 ? r[i] : r[s[13:12]]) ^ s[3*i+2];
	endfunction : expClk

	function logic [3:0] expPul(logic [15:0] s, logic f);
		for (int i = 0; i < 4; i++)
			expPul[i] = f ^ s[3*i+1];
	endfunction : expPul

	// Hang guard, far above the expected run length
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			tally_and_finish;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'h04a9956f));
		repeat (6) @(posedge clock);
		arst_n <= 1;
		for (int k = 0; k < 3; k++)
		begin
			apb(0, k == 0 ? OFS_ENABLE : k == 1 ? OFS_SELECT : OFS_SRESET, 0);
			chk(q, 0); // reset values
		end
		// Static timing sources, reserved bits always written as zero
		for (int k = 0; k < 16; k++)
		begin
			// reserved enable bits kept at zero
			en = 16'($urandom) & MASK_ENABLE;
			// Pair 0 walks all eight shaping codes, the rate field all four, the rest random
			sel = (16'($urandom) & 16'h0ff8) | 16'(k % 8) | 16'((k % 4) << 12);
			rateClock <= 4'($urandom);
			refFrame <= 1'($urandom);
			dpIn <= 3'($urandom);
			apb(1, OFS_ENABLE, {16'h0, en});
			apb(1, OFS_SELECT, {16'h0, sel});
			repeat (4) @(posedge clock);
			chk(32'(ocOe), 32'(en[3:0]));
			chk(32'(fpOe), 32'(en[3:0]));
			chk(32'(dpOe), 32'(en[8:6]));
			chk(32'(sc), 32'(expClk(sel, rateClock) & en[3:0]));
			chk(32'(sp), 32'(expPul(sel, refFrame) & en[3:0]));
			chk(32'(sd), 32'(dpIn & en[8:6]));
			apb(0, OFS_SELECT, 0);
			chk(q, {16'h0, sel});
		end
		// One-cycle frame pulse: straddling pairs stretch it, pair 3 precedes
		refFrame <= 0;
		en = MASK_ENABLE;
		apb(1, OFS_ENABLE, {16'h0, en});
		apb(1, OFS_SELECT, 32'h0000_0200);
		repeat (3) @(posedge clock);
		refFrame <= 1;
		@(posedge clock);
		refFrame <= 0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk(32'(sp), 32'hf);
		@(negedge clock);
		chk(32'(sp), 32'h7);
		@(negedge clock);
		chk(32'(sp), 32'h0);
		// Soft reset holds outputs low, enables untouched
		dpIn <= 3'h7;
		apb(1, OFS_SRESET, 32'h2);
		repeat (3) @(posedge clock);
		chk(32'(switchSoftReset), 1);
		chk(32'(dp), 0);
		chk(32'(oc), 0);
		chk(32'(fp), 0);
		chk(32'(dpOe), 32'(en[8:6]));
		apb(1, OFS_SRESET, 0);
		repeat (2) @(posedge clock);
		chk(32'(switchSoftReset), 0);
		chk(32'(dp), 7);
		// Unmapped address answers with an error and zero data
		apb(0, 16'h000c, 0);
		chk({31'h0, e}, 1);
		chk(q, 0);
		tally_and_finish;
	end
endmodule : tb

// >>> tcfoc_ctrl.sv
// APB register block steering output clocks, frame pulses and soft reset
`timescale 1ns/1ps

// Function
// R1: The soft reset bit, while high, holds the switching blocks in reset.
// R2: Software writes zero to reserved enable bits 15..9, 5 and 4.
// R3: Enable bit 7 drives delayed frame pulse 1, else it floats.
// R4: Enable bit 6 drives delayed frame pulse 0, else it floats.
// R5: Enable bit 0 drives or floats clock and pulse pair 0.
// R6: Enable bit 1 drives or floats clock and pulse pair 1.
// R7: Enable bit 2 drives or floats clock and pulse pair 2.
// R8: Enable bit 3 drives or floats clock and pulse pair 3.
// R9: Select bits 13..12 pick the pair 3 clock rate and pulse width; the code uses them for the clock rate only.
// R10: Per-pair select bits set clock polarity, pulse polarity and position.
module tcfoc_ctrl
	import tcfoc_pkg::*;
(
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   arst_n,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [15:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Timing sources from pins
	input  wire logic [PAIR_COUNT-1:0]  rateClock,
	input  wire logic                   refFrame,
	input  wire logic [DELAY_COUNT-1:0] delayedPulseIn,
	// Switching block reset
	output logic                        switchSoftReset,
	// Output clock and frame pulse pins
	output logic [PAIR_COUNT-1:0]       outClock,
	output logic [PAIR_COUNT-1:0]       outClockOe,
	output logic [PAIR_COUNT-1:0]       outFramePulse,
	output logic [PAIR_COUNT-1:0]       outFramePulseOe,
	output logic [DELAY_COUNT-1:0]      delayedFramePulse,
	output logic [DELAY_COUNT-1:0]      delayedFramePulseOe
);

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [15:0] outputEnable;
	logic [15:0] pulseSelect;
	logic [15:0] softReset;
	logic [15:0] next_outputEnable;
	logic [15:0] next_pulseSelect;
	logic [15:0] next_softReset;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        setupPhase;
	logic        writeAccess;

	function automatic logic isMapped(input logic [15:0] addr);
		isMapped = (addr == OFS_ENABLE) || (addr == OFS_SELECT) || (addr == OFS_SRESET);
	endfunction : isMapped

	// Zero wait states: reads are fetched in the setup cycle
	assign setupPhase  = psel && !penable;
	assign writeAccess = psel && penable && pwrite;
	assign pready      = 1'b1;

	// Next register values and read data
	always_comb
	begin
		next_outputEnable = outputEnable;
		next_pulseSelect  = pulseSelect;
		next_softReset    = softReset;
		next_prdata       = prdata;
		next_pslverr      = pslverr;
		if (setupPhase)
		begin
			next_pslverr = !isMapped(paddr);
			if (pwrite)
				next_prdata = 32'h0000_0000;
			else if (paddr == OFS_ENABLE)
				next_prdata = {16'h0000, outputEnable};
			else if (paddr == OFS_SELECT)
				next_prdata = {16'h0000, pulseSelect};
			else if (paddr == OFS_SRESET)
				next_prdata = {16'h0000, softReset};
			else
				next_prdata = 32'h0000_0000;
		end
		// Reserved bits are not stored, so they read back zero
		if (writeAccess)
		begin
			if (paddr == OFS_ENABLE)
				next_outputEnable = pwdata[15:0] & MASK_ENABLE;
			else if (paddr == OFS_SELECT)
				next_pulseSelect = pwdata[15:0] & MASK_SELECT;
			else if (paddr == OFS_SRESET)
				next_softReset = pwdata[15:0] & MASK_SRESET;
		end
	end

	// Register state
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			outputEnable <= RESET_ENABLE;
			pulseSelect  <= RESET_SELECT;
			softReset    <= RESET_SRESET;
			prdata       <= 32'h0000_0000;
			pslverr      <= 1'b0;
		end
		else
		begin
			outputEnable <= next_outputEnable;
			pulseSelect  <= next_pulseSelect;
			softReset    <= next_softReset;
			prdata       <= next_prdata;
			pslverr      <= next_pslverr;
		end
	end

	// R1: soft reset level
	assign switchSoftReset = softReset[POS_SRESET];

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [PAIR_COUNT:0] syncMeta;
	logic [PAIR_COUNT:0] syncOut;
	logic [PAIR_COUNT:0] rawPins;

	assign rawPins = {refFrame, rateClock};

	// Two flops on every asynchronous timing input
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncMeta <= '0;
			syncOut  <= '0;
		end
		else
		begin
			syncMeta <= rawPins;
			syncOut  <= syncMeta;
		end
	end

	// ------------------------------------------------------------
	// Output pairs
	// ------------------------------------------------------------
	logic [1:0]            rateSelect;
	logic [PAIR_COUNT-1:0] pairSource;

	assign rateSelect = pulseSelect[POS_RATE_LO+1:POS_RATE_LO];

	// R9: pair 3 takes the rate clock picked by the select field
	always_comb
	begin
		pairSource    = syncOut[PAIR_COUNT-1:0];
		pairSource[3] = syncOut[rateSelect];
	end

	genvar gi;
	generate
		for (gi = 0; gi < PAIR_COUNT; gi++)
		begin : g_pair
			// R5: each pair gated by its enable bit (R6, R7, R8 likewise)
			// R10: polarity and position bits per pair
			tcfoc_pair u_pair (
				.clock         (clock),
				.arst_n        (arst_n),
				.srcClock      (pairSource[gi]),
				.srcFrame      (syncOut[PAIR_COUNT]),
				.enable        (outputEnable[POS_PAIR_EN+gi]),
				.clockPolarity (pulseSelect[3*gi+POS_SEL_CPOL]),
				.pulsePolarity (pulseSelect[3*gi+POS_SEL_PPOL]),
				.pulsePosition (pulseSelect[3*gi+POS_SEL_POS]),
				.holdReset     (switchSoftReset),
				.pinClock      (outClock[gi]),
				.pinClockOe    (outClockOe[gi]),
				.pinPulse      (outFramePulse[gi]),
				.pinPulseOe    (outFramePulseOe[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Delayed frame pulses
	// ------------------------------------------------------------
	logic [DELAY_COUNT-1:0] next_delayedFramePulse;

	// Core pulses share this clock, so no synchroniser is needed
	always_comb
	begin
		next_delayedFramePulse = switchSoftReset ? '0 : delayedPulseIn;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			delayedFramePulse <= '0;
		else
			delayedFramePulse <= next_delayedFramePulse;
	end

	// R3: bit 7 enables pulse 1; R4: bit 6 enables pulse 0
	assign delayedFramePulseOe = outputEnable[POS_DELAY_EN+DELAY_COUNT-1:POS_DELAY_EN];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_enWrite;
		writeAccess && (paddr == OFS_ENABLE);
	endsequence

	sequence s_selWrite;
		writeAccess && (paddr == OFS_SELECT);
	endsequence

	a_soft_reset_hold: assert property ( // R1
		(writeAccess && paddr == OFS_SRESET) |=> (switchSoftReset == $past(pwdata[1]))
		##1 (switchSoftReset ? (delayedFramePulse == '0 && outClock == '0) : 1'b1))
		else $error("soft reset bit not applied");
	a_delay1_gate: assert property ( // R3
		s_enWrite |=> (delayedFramePulseOe[1] == $past(pwdata[7])))
		else $error("delayed pulse 1 enable wrong");
	a_delay0_gate: assert property ( // R4
		s_enWrite |=> (delayedFramePulseOe[0] == $past(pwdata[6])))
		else $error("delayed pulse 0 enable wrong");
	a_pair0_gate: assert property ( // R5
		s_enWrite |=> (outClockOe[0] == $past(pwdata[0])) && (outFramePulseOe[0] == outClockOe[0]))
		else $error("pair 0 enable wrong");
	a_pair1_gate: assert property ( // R6
		s_enWrite |=> (outClockOe[1] == $past(pwdata[1])) && (outFramePulseOe[1] == outClockOe[1]))
		else $error("pair 1 enable wrong");
	a_pair2_gate: assert property ( // R7
		s_enWrite |=> (outClockOe[2] == $past(pwdata[2])) && (outFramePulseOe[2] == outClockOe[2]))
		else $error("pair 2 enable wrong");
	a_pair3_gate: assert property ( // R8
		s_enWrite |=> (outClockOe[3] == $past(pwdata[3])) && (outFramePulseOe[3] == outClockOe[3]))
		else $error("pair 3 enable wrong");
	a_pair3_rate: assert property ( // R9
		(!switchSoftReset && $stable(pulseSelect)) |=>
		(outClock[3] == ($past(syncOut[rateSelect]) ^ $past(pulseSelect[11]))))
		else $error("pair 3 clock not from selected rate");
	a_pulse_shape: assert property ( // R10
		s_selWrite ##1 (!switchSoftReset && pulseSelect[2:0] == 3'b001) |=>
		(outFramePulse[0] == $past(syncOut[PAIR_COUNT])))
		else $error("pair 0 preceding pulse wrong");

endmodule : tcfoc_ctrl

// >>> tcfoc_pair.sv
// One output clock and frame pulse pair with polarity and position shaping
`timescale 1ns/1ps
module tcfoc_pair
	import tcfoc_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic arst_n,
	// Timing sources, already synchronised
	input  wire logic srcClock,
	input  wire logic srcFrame,
	// Controls
	input  wire logic enable,
	input  wire logic clockPolarity,
	input  wire logic pulsePolarity,
	input  wire logic pulsePosition,
	input  wire logic holdReset,
	// Pins
	output logic      pinClock,
	output logic      pinClockOe,
	output logic      pinPulse,
	output logic      pinPulseOe
);

	logic prevFrame;
	logic next_pinClock;
	logic next_pinPulse;
	logic next_prevFrame;
	logic shaped;

	// Next values; straddling stretches the pulse over the boundary
	always_comb
	begin
		next_prevFrame = srcFrame;
		shaped         = pulsePosition ? srcFrame : (srcFrame | prevFrame);
		next_pinClock  = srcClock ^ clockPolarity;
		next_pinPulse  = shaped ^ pulsePolarity;
		if (holdReset)
		begin
			next_pinClock = 1'b0;  // Quiet pins while the switch is held
			next_pinPulse = 1'b0;
		end
	end

	// Registered pin data
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinClock  <= 1'b0;
			pinPulse  <= 1'b0;
			prevFrame <= 1'b0;
		end
		else
		begin
			pinClock  <= next_pinClock;
			pinPulse  <= next_pinPulse;
			prevFrame <= next_prevFrame;
		end
	end

	// Both pins of a pair share one enable
	assign pinClockOe = enable;
	assign pinPulseOe = enable;

endmodule : tcfoc_pair

// >>> tcfoc_pkg.sv
// Constants for the output clock and frame pulse control block
package tcfoc_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [15:0] OFS_ENABLE = 16'h0000;
	localparam logic [15:0] OFS_SELECT = 16'h0004;
	localparam logic [15:0] OFS_SRESET = 16'h0008;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PAIR_COUNT    = 4;
	localparam int DELAY_COUNT   = 3;
	localparam int POS_PAIR_EN   = 0;   // Bits 3..0, one per pair
	localparam int POS_DELAY_EN  = 6;   // Bits 8..6, one per delayed pulse
	localparam int POS_SEL_POS   = 0;   // Bit 3*i: pulse position
	localparam int POS_SEL_PPOL  = 1;   // Bit 3*i+1: pulse polarity
	localparam int POS_SEL_CPOL  = 2;   // Bit 3*i+2: clock polarity
	localparam int POS_RATE_LO   = 12;  // Bits 13..12: pair 3 rate
	localparam int POS_SRESET    = 1;

	// ------------------------------------------------------------
	// Writable masks and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] MASK_ENABLE  = 16'h01cf;
	localparam logic [15:0] MASK_SELECT  = 16'h3fff;
	localparam logic [15:0] MASK_SRESET  = 16'h0002;
	localparam logic [15:0] RESET_ENABLE = 16'h0000;
	localparam logic [15:0] RESET_SELECT = 16'h0000;
	localparam logic [15:0] RESET_SRESET = 16'h0000;

endpackage : tcfoc_pkg

// >>> tcfoc_sink.sv
// Downstream timing consumer that sees the pulled-down output pins
`timescale 1ns/1ps
module tcfoc_sink
(
	// Pin data and enables from the block
	input  wire logic [3:0] clk,
	input  wire logic [3:0] clkOe,
	input  wire logic [3:0] pul,
	input  wire logic [3:0] pulOe,
	input  wire logic [2:0] dly,
	input  wire logic [2:0] dlyOe,
	// Levels seen on the board
	output wire logic [3:0] seenClk,
	output wire logic [3:0] seenPul,
	output wire logic [2:0] seenDly
);
	// Floating pins fall to the pull-down level, so no stale value shows
	assign seenClk = clk & clkOe;
	assign seenPul = pul & pulOe;
	assign seenDly = dly & dlyOe;
endmodule : tcfoc_sink
